// ===== inc/vga_status_params.svh
// port addresses, field positions and reset values of the general
// control and status register group; assumes 16-bit i/o addresses
`ifndef VGA_STATUS_PARAMS_SVH
`define VGA_STATUS_PARAMS_SVH

`define PORT_STATUS_MONO    16'h03BA
`define PORT_STATUS_COLOUR  16'h03DA
`define PORT_STATUS_ZERO    16'h03C2
`define PORT_FEATURE_READ   16'h03CA
`define PORT_MISC_READ      16'h03CC

`define MISC_EMU_BIT        0
`define MISC_MEM_EN_BIT     1
`define MISC_CLK_LSB        2
`define MISC_PAGE_BIT       5
`define MISC_HPOL_BIT       6
`define MISC_VPOL_BIT       7
`define FEATURE_VSYNC_BIT   3
`define ST0_SENSE_BIT       4
`define ST0_IRQ_BIT         7
`define ST1_BLANK_BIT       0
`define ST1_VRETRACE_BIT    3
`define ST1_FB_LSB          4

`define MISC_RESET          8'h00
`define FEATURE_RESET       8'h00
`define MISC_WMASK          8'hEF
`define FEATURE_WMASK       8'h08
`define UNMAPPED_DATA       8'h00
`define DOT_CLK_FIXED_SEL   2'h0

`endif

// ===== inc/vga_status_pkg.sv
// types shared by the general status register group
// no dependencies
package vga_status_pkg;

  typedef enum logic [1:0] {
    mode_native,
    mode_centered,
    mode_upper_left
  } display_mode_t;

  typedef enum logic [2:0] {
    port_none,
    port_zero_misc,
    port_one_feature,
    port_feature_rd,
    port_misc_rd
  } port_t;

  typedef enum logic {
    acc_idle,
    acc_answer
  } access_state_t;

endpackage

// ===== hw/vga_retrace_source.sv
// retrace and blanking status source selection
// assumes all blanking inputs are synchronous levels on mclk_i
`timescale 1ns/100ps
`default_nettype none

module vga_retrace_source
(
  input  wire logic mclk_i,
  input  wire logic nrst_i,
  input  wire logic vga_disable_i,
  input  wire logic vgen_vblank_i,
  input  wire logic vgen_hblank_i,
  input  wire logic pipe_sel_i,
  input  wire logic pipe_a_vblank_i,
  input  wire logic pipe_a_hblank_i,
  input  wire logic pipe_b_vblank_i,
  input  wire logic pipe_b_hblank_i,
  output logic      vretrace_o,
  output logic      blank_o
);

  logic vb;
  logic hb;

  // internal pixel generation timing, not the sync sent out
  always_comb
  begin
    if (!vga_disable_i)
    begin
      vb = vgen_vblank_i;
      hb = vgen_hblank_i;
    end
    else if (pipe_sel_i)
    begin
      vb = pipe_b_vblank_i;
      hb = pipe_b_hblank_i;
    end
    else
    begin
      vb = pipe_a_vblank_i;
      hb = pipe_a_hblank_i;
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      vretrace_o <= 1'b0;
      blank_o    <= 1'b0;
    end
    else
    begin
      vretrace_o <= vb;
      blank_o    <= vb | hb;
    end
  end

endmodule

`default_nettype wire

// ===== hw/vga_colour_feedback.sv
// picks two of the eight palette colour bits for status feedback
// assumes colour bits synchronous to mclk_i
`timescale 1ns/100ps
`default_nettype none

module vga_colour_feedback
(
  input  wire logic       mclk_i,
  input  wire logic       nrst_i,
  input  wire logic [7:0] colour_i,
  input  wire logic [1:0] sel_i,
  output logic      [1:0] feedback_o
);

  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      feedback_o <= 2'h0;
    else
      feedback_o <= colour_i[{sel_i, 1'b0} +: 2];
  end

endmodule

`default_nettype wire

// ===== hw/vga_general_status_regs.sv
// general control and status register group on legacy i/o ports
// assumes a host issuing one-cycle read/write strobes with byte lanes
`timescale 1ns/100ps
`default_nettype none
`include "vga_status_params.svh"

module vga_general_status_regs
(
  input  wire logic                         mclk_i,
  input  wire logic                         nrst_i,
  input  wire logic [15:0]                  io_addr_i,
  input  wire logic                         io_rd_i,
  input  wire logic                         io_wr_i,
  input  wire logic [1:0]                   io_be_i,
  input  wire logic [15:0]                  io_wdata_i,
  output logic      [15:0]                  io_rdata_o,
  output logic                              io_ack_o,
  output logic                              io_claim_o,
  output logic                              io_misaligned_o,
  input  wire logic                         vga_disable_i,
  input  wire logic                         vgen_vblank_i,
  input  wire logic                         vgen_hblank_i,
  input  wire logic                         vga_pipe_sel_i,
  input  wire logic                         pipe_a_vblank_i,
  input  wire logic                         pipe_a_hblank_i,
  input  wire logic                         pipe_b_vblank_i,
  input  wire logic                         pipe_b_hblank_i,
  input  wire logic [7:0]                   palette_colour_i,
  input  wire logic [1:0]                   colour_plane_sel_i,
  input  wire vga_status_pkg::display_mode_t display_mode_i,
  output logic                              emulation_colour_o,
  output logic                              mem_window_en_o,
  output logic                              page_select_o,
  output logic                              hsync_neg_o,
  output logic                              vsync_neg_o,
  output logic      [1:0]                   dot_clk_sel_o,
  output logic                              dot_clk_fixed_o,
  output logic                              feature_vsync_ctl_o
);

  logic [7:0]                    misc_reg;
  logic [7:0]                    misc_next;
  logic [7:0]                    feature_reg;
  logic [7:0]                    feature_next;
  vga_status_pkg::access_state_t acc_reg;
  logic                          vretrace;
  logic                          blank;
  logic [1:0]                    feedback;
  logic [7:0]                    status_zero;
  logic [7:0]                    status_one;
  logic                          req;
  logic                          word_req;
  logic                          misaligned;
  logic [15:0]                   lane_addr [2];
  logic [15:0]                   rdata_next;
  logic                          claim_next;

  // one decode shared by the read and the write paths of both lanes
  function automatic vga_status_pkg::port_t decode_port
  (
    input logic [15:0] addr,
    input logic        colour
  );
    logic [15:0] status_one_port;
    status_one_port = colour ? `PORT_STATUS_COLOUR
                             : `PORT_STATUS_MONO;
    if (addr == `PORT_STATUS_ZERO)
      decode_port = vga_status_pkg::port_zero_misc;
    else if (addr == status_one_port)
      decode_port = vga_status_pkg::port_one_feature;
    else if (addr == `PORT_FEATURE_READ)
      decode_port = vga_status_pkg::port_feature_rd;
    else if (addr == `PORT_MISC_READ)
      decode_port = vga_status_pkg::port_misc_rd;
    else
      decode_port = vga_status_pkg::port_none;
  endfunction

  function automatic logic [7:0] read_port
  (
    input vga_status_pkg::port_t p,
    input logic [7:0]            st0,
    input logic [7:0]            st1,
    input logic [7:0]            fc,
    input logic [7:0]            misc
  );
    case (p)
      vga_status_pkg::port_zero_misc:
        read_port = st0;
      vga_status_pkg::port_one_feature:
        read_port = st1;
      vga_status_pkg::port_feature_rd:
        read_port = fc;
      vga_status_pkg::port_misc_rd:
        read_port = misc;
      default:
        read_port = `UNMAPPED_DATA;
    endcase
  endfunction

  vga_retrace_source u_retrace
  (
    .mclk_i          (mclk_i),
    .nrst_i          (nrst_i),
    .vga_disable_i   (vga_disable_i),
    .vgen_vblank_i   (vgen_vblank_i),
    .vgen_hblank_i   (vgen_hblank_i),
    .pipe_sel_i      (vga_pipe_sel_i),
    .pipe_a_vblank_i (pipe_a_vblank_i),
    .pipe_a_hblank_i (pipe_a_hblank_i),
    .pipe_b_vblank_i (pipe_b_vblank_i),
    .pipe_b_hblank_i (pipe_b_hblank_i),
    .vretrace_o      (vretrace),
    .blank_o         (blank)
  );

  vga_colour_feedback u_feedback
  (
    .mclk_i     (mclk_i),
    .nrst_i     (nrst_i),
    .colour_i   (palette_colour_i),
    .sel_i      (colour_plane_sel_i),
    .feedback_o (feedback)
  );

  // status zero: only the sense bit is ever set
  always_comb
  begin
    status_zero                 = 8'h00;
    status_zero[`ST0_IRQ_BIT]   = 1'b0;
    status_zero[`ST0_SENSE_BIT] = 1'b1;
  end

  always_comb
  begin
    status_one                                = 8'h00;
    status_one[`ST1_BLANK_BIT]                = blank;
    status_one[`ST1_VRETRACE_BIT]             = vretrace;
    status_one[`ST1_FB_LSB +: 2]              = feedback;
  end

  assign lane_addr[0] = io_addr_i;
  assign lane_addr[1] = io_addr_i + 16'h0001;

  assign req      = io_rd_i | io_wr_i;
  assign word_req = io_be_i == 2'h3;
  // odd word cycles are not decoded at all rather than split
  assign misaligned = word_req & io_addr_i[0];

  // read data per lane; a lane not enabled reads as zero
  always_comb
  begin
    rdata_next = 16'h0000;
    claim_next = 1'b0;
    for (int i = 0; i < 2; i++)
    begin
      if (io_be_i[i] && !misaligned)
      begin
        rdata_next[i*8 +: 8] = read_port(
          decode_port(lane_addr[i], misc_reg[`MISC_EMU_BIT]),
          status_zero, status_one, feature_reg, misc_reg);
        if (decode_port(lane_addr[i], misc_reg[`MISC_EMU_BIT])
            != vga_status_pkg::port_none)
          claim_next = 1'b1;
      end
    end
  end

  // write path: each enabled lane steers its own byte
  always_comb
  begin
    misc_next    = misc_reg;
    feature_next = feature_reg;
    for (int i = 0; i < 2; i++)
    begin
      if (io_wr_i && io_be_i[i] && !misaligned)
      begin
        case (decode_port(lane_addr[i], misc_reg[`MISC_EMU_BIT]))
          vga_status_pkg::port_zero_misc:
            misc_next = io_wdata_i[i*8 +: 8] & `MISC_WMASK;
          vga_status_pkg::port_one_feature:
            feature_next = io_wdata_i[i*8 +: 8]
                           & `FEATURE_WMASK;
          default:
            ; // read-back and unmapped ports ignore writes
        endcase
      end
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      misc_reg <= `MISC_RESET;
    else
      misc_reg <= misc_next;
  end

  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      feature_reg <= `FEATURE_RESET;
    else
      feature_reg <= feature_next;
  end

  // bus answer: data and ack one cycle after the strobe
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      acc_reg         <= vga_status_pkg::acc_idle;
      io_ack_o        <= 1'b0;
      io_rdata_o      <= 16'h0000;
      io_claim_o      <= 1'b0;
      io_misaligned_o <= 1'b0;
    end
    else
    begin
      case (acc_reg)
        vga_status_pkg::acc_idle:
        begin
          if (req)
          begin
            acc_reg         <= vga_status_pkg::acc_answer;
            io_ack_o        <= 1'b1;
            io_rdata_o      <= io_rd_i ? rdata_next : 16'h0000;
            io_claim_o      <= claim_next;
            io_misaligned_o <= misaligned;
          end
        end
        vga_status_pkg::acc_answer:
        begin
          // back-to-back strobes still get one answer each
          acc_reg         <= req ? vga_status_pkg::acc_answer
                                 : vga_status_pkg::acc_idle;
          io_ack_o        <= req;
          io_rdata_o      <= (req && io_rd_i) ? rdata_next : 16'h0000;
          io_claim_o      <= req & claim_next;
          io_misaligned_o <= req & misaligned;
        end
        default:
        begin
          acc_reg  <= vga_status_pkg::acc_idle;
          io_ack_o <= 1'b0;
        end
      endcase
    end
  end

  assign emulation_colour_o  = misc_reg[`MISC_EMU_BIT];
  assign mem_window_en_o     = misc_reg[`MISC_MEM_EN_BIT];
  assign page_select_o       = misc_reg[`MISC_PAGE_BIT];
  assign hsync_neg_o         = misc_reg[`MISC_HPOL_BIT];
  assign vsync_neg_o         = misc_reg[`MISC_VPOL_BIT];
  assign feature_vsync_ctl_o = feature_reg[`FEATURE_VSYNC_BIT];

  // panel modes ignore the select; the panel dictates the dot clock
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      dot_clk_sel_o   <= `DOT_CLK_FIXED_SEL;
      dot_clk_fixed_o <= 1'b0;
    end
    else if (display_mode_i == vga_status_pkg::mode_native)
    begin
      dot_clk_sel_o   <= misc_reg[`MISC_CLK_LSB +: 2];
      dot_clk_fixed_o <= 1'b0;
    end
    else
    begin
      dot_clk_sel_o   <= `DOT_CLK_FIXED_SEL;
      dot_clk_fixed_o <= 1'b1;
    end
  end

endmodule

`default_nettype wire

// ===== verification/vga_status_checker.sv
// port-level checks of the general status register group
// assumes single-clock design, bound by the statement at the foot
`timescale 1ns/100ps
`default_nettype none

module vga_status_checker
(
  input wire logic                          mclk_i,
  input wire logic                          nrst_i,
  input wire logic [15:0]                   io_addr_i,
  input wire logic                          io_rd_i,
  input wire logic                          io_wr_i,
  input wire logic [1:0]                    io_be_i,
  input wire logic [15:0]                   io_wdata_i,
  input wire logic [15:0]                   io_rdata_o,
  input wire logic                          io_ack_o,
  input wire logic                          io_claim_o,
  input wire vga_status_pkg::display_mode_t display_mode_i,
  input wire logic                          emulation_colour_o,
  input wire logic [1:0]                    dot_clk_sel_o,
  input wire logic                          dot_clk_fixed_o,
  input wire logic                          feature_vsync_ctl_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!nrst_i);

  logic [15:0] st1_port;
  logic [15:0] off_port;
  assign st1_port = emulation_colour_o ? 16'h03DA : 16'h03BA;
  assign off_port = emulation_colour_o ? 16'h03BA : 16'h03DA;

  property p_ack;
    io_ack_o == $past(io_rd_i || io_wr_i);
  endproperty
  a_ack: assert property (p_ack)
    else $error("ack not one cycle after strobe");
  property p_st0;
    io_rd_i && io_addr_i == 16'h03C2 && io_be_i == 2'b01
      |=> io_rdata_o == 16'h0010 && io_claim_o;
  endproperty
  a_st0: assert property (p_st0)
    else $error("status zero read wrong");
  property p_misc_wr;
    io_wr_i && io_addr_i == 16'h03C2 && io_be_i[0]
      |=> emulation_colour_o == $past(io_wdata_i[0]);
  endproperty
  a_misc_wr: assert property (p_misc_wr)
    else $error("misc write at status zero port lost");
  property p_misc_rd;
    io_rd_i && io_addr_i == 16'h03CC && io_be_i == 2'b01
      |=> io_rdata_o[0] == emulation_colour_o && !io_rdata_o[4];
  endproperty
  a_misc_rd: assert property (p_misc_rd)
    else $error("misc readback wrong");
  property p_fc_rd;
    io_rd_i && io_addr_i == 16'h03CA && io_be_i == 2'b01
      |=> io_rdata_o == {12'h000, feature_vsync_ctl_o, 3'h0};
  endproperty
  a_fc_rd: assert property (p_fc_rd)
    else $error("feature readback wrong");
  property p_fc_wr;
    io_wr_i && io_be_i == 2'b01 && io_addr_i == st1_port
      |=> feature_vsync_ctl_o == $past(io_wdata_i[3]);
  endproperty
  a_fc_wr: assert property (p_fc_wr)
    else $error("feature write at selected port lost");
  property p_st1_off;
    io_rd_i && io_be_i == 2'b01 && io_addr_i == off_port
      |=> !io_claim_o && io_rdata_o == 16'h0000;
  endproperty
  a_st1_off: assert property (p_st1_off)
    else $error("non-selected status port answered");
  property p_ro_wr;
    io_wr_i && io_addr_i == 16'h03CC |=> $stable(emulation_colour_o);
  endproperty
  a_ro_wr: assert property (p_ro_wr)
    else $error("write to read port changed misc");
  property p_dot;
    display_mode_i != vga_status_pkg::mode_native
      |=> dot_clk_fixed_o && dot_clk_sel_o == 2'h0;
  endproperty
  a_dot: assert property (p_dot)
    else $error("panel mode dot clock not fixed");

  c_st1: cover property (io_rd_i && io_addr_i == st1_port);
  c_fc: cover property (io_wr_i && io_addr_i == st1_port);
  c_panel: cover property (dot_clk_fixed_o);
endmodule

bind vga_general_status_regs vga_status_checker chk_u
(
  .mclk_i(mclk_i), .nrst_i(nrst_i), .io_addr_i(io_addr_i),
  .io_rd_i(io_rd_i), .io_wr_i(io_wr_i), .io_be_i(io_be_i),
  .io_wdata_i(io_wdata_i), .io_rdata_o(io_rdata_o),
  .io_ack_o(io_ack_o), .io_claim_o(io_claim_o),
  .display_mode_i(display_mode_i),
  .emulation_colour_o(emulation_colour_o),
  .dot_clk_sel_o(dot_clk_sel_o), .dot_clk_fixed_o(dot_clk_fixed_o),
  .feature_vsync_ctl_o(feature_vsync_ctl_o)
);
`default_nettype wire

// ===== verification/io_host_model.sv
// host issuing legacy i/o port cycles
// assumes one-cycle strobes answered by ack one cycle later
`timescale 1ns/100ps
`default_nettype none

module io_host_model
(
  input  wire logic        mclk_i,
  input  wire logic [15:0] rdata_i,
  input  wire logic        ack_i,
  input  wire logic        claim_i,
  input  wire logic        mis_i,
  output logic      [15:0] addr_o,
  output logic             rd_o,
  output logic             wr_o,
  output logic      [1:0]  be_o,
  output logic      [15:0] wdata_o
);
  initial
  begin
    {addr_o, rd_o, wr_o, be_o, wdata_o} = '0;
  end

  // only byte or word lanes exist, so no dword cycle
  task automatic cyc(input logic w, input logic [15:0] a,
                     input logic [1:0] b, input logic [15:0] d,
                     output logic [15:0] q, output logic c,
                     output logic m, output logic k);
    @(negedge mclk_i);
    addr_o = a;
    be_o = b;
    wdata_o = d;
    rd_o = !w;
    wr_o = w;
    @(negedge mclk_i);
    rd_o = 1'b0;
    wr_o = 1'b0;
    q = rdata_i;
    c = claim_i;
    m = mis_i;
    k = ack_i;
    // released lines must not look like a held cycle
    addr_o = ~a;
    wdata_o = ~d;
  endtask
endmodule
`default_nettype wire

// ===== verification/tb_top.sv
// self-checking bench of the general status register group
// assumes io_host_model drives the port cycles
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  logic mclk, nrst, rd_stb, wr_stb, ack, claim, mis;
  logic [15:0] addr, wdata, rdata;
  logic [1:0] be, psl, dsel;
  logic [7:0] pal, sv;
  logic emu, mem, page, hn, vn, dfix, fvs;
  vga_status_pkg::display_mode_t mode;
  int bad_count = 0;
  int num_checks = 0;

  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  io_host_model host_u (.mclk_i(mclk), .rdata_i(rdata), .ack_i(ack),
    .claim_i(claim), .mis_i(mis), .addr_o(addr), .rd_o(rd_stb),
    .wr_o(wr_stb), .be_o(be), .wdata_o(wdata));

  vga_general_status_regs dut_u (.mclk_i(mclk), .nrst_i(nrst),
    .io_addr_i(addr), .io_rd_i(rd_stb), .io_wr_i(wr_stb), .io_be_i(be),
    .io_wdata_i(wdata), .io_rdata_o(rdata), .io_ack_o(ack),
    .io_claim_o(claim), .io_misaligned_o(mis), .vga_disable_i(sv[7]),
    .vgen_vblank_i(sv[6]), .vgen_hblank_i(sv[5]),
    .vga_pipe_sel_i(sv[4]), .pipe_a_vblank_i(sv[3]),
    .pipe_a_hblank_i(sv[2]), .pipe_b_vblank_i(sv[1]),
    .pipe_b_hblank_i(sv[0]), .palette_colour_i(pal),
    .colour_plane_sel_i(psl), .display_mode_i(mode),
    .emulation_colour_o(emu), .mem_window_en_o(mem),
    .page_select_o(page), .hsync_neg_o(hn), .vsync_neg_o(vn),
    .dot_clk_sel_o(dsel), .dot_clk_fixed_o(dfix),
    .feature_vsync_ctl_o(fvs));

  task automatic chk(input string n, input logic [15:0] s, e);
    num_checks++;
    if (s !== e)
    begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic rd(input logic [15:0] a, input logic [1:0] b,
                    input logic [15:0] e, input logic ec);
    logic [15:0] q;
    logic c, m, k;
    host_u.cyc(1'b0, a, b, 16'h0000, q, c, m, k);
    chk("rdata", q, e);
    chk("claim", {15'h0, c}, {15'h0, ec});
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    logic [15:0] q;
    logic c, m, k;
    host_u.cyc(1'b1, a, 2'b01, d, q, c, m, k);
    chk("ack", {15'h0, k}, 16'h0001);
  endtask

  // status inputs need two cycles to reach read data
  task automatic stat(input logic [7:0] v, input logic [15:0] e);
    @(negedge mclk);
    sv = v;
    repeat (3) @(negedge mclk);
    rd(16'h03BA, 2'b01, e, 1'b1);
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    repeat (2000) @(posedge mclk);
    bad_count++;
    complete_run();
  end

  initial
  begin : main_seq
    logic [15:0] q;
    logic c, m, k;
    nrst = 1'b0;
    sv = 8'h00;
    pal = 8'h00;
    psl = 2'h0;
    mode = vga_status_pkg::mode_native;
    repeat (20) @(negedge mclk);
    nrst = 1'b1;
    rd(16'h03C2, 2'b01, 16'h0010, 1'b1);
    rd(16'h03CC, 2'b01, 16'h0000, 1'b1);
    rd(16'h03CA, 2'b01, 16'h0000, 1'b1);
    rd(16'h03C0, 2'b01, 16'h0000, 1'b0);
    rd(16'h03C2, 2'b11, 16'h0010, 1'b1);
    wr(16'h03CC, 16'h00FF);
    wr(16'h03CA, 16'h00FF);
    wr(16'h03DA, 16'h0008);
    rd(16'h03CC, 2'b01, 16'h0000, 1'b1);
    rd(16'h03CA, 2'b01, 16'h0000, 1'b1);
    wr(16'h03BA, 16'h00FF);
    rd(16'h03CA, 2'b01, 16'h0008, 1'b1);
    rd(16'h03DA, 2'b01, 16'h0000, 1'b0);
    wr(16'h03C2, 16'h00FF);
    chk("misc", {10'h0, vn, hn, page, mem, emu, fvs}, 16'h003F);
    rd(16'h03CC, 2'b01, 16'h00EF, 1'b1);
    rd(16'h03CB, 2'b10, 16'hEF00, 1'b1);
    wr(16'h03DA, 16'h0000);
    rd(16'h03CA, 2'b01, 16'h0000, 1'b1);
    rd(16'h03BA, 2'b01, 16'h0000, 1'b0);
    host_u.cyc(1'b0, 16'h03C3, 2'b11, 16'h0000, q, c, m, k);
    chk("misaligned", {m, q[14:0]}, 16'h8000);
    wr(16'h03C2, 16'h0004);
    @(negedge mclk);
    chk("dot select", {13'h0, dsel, dfix}, 16'h0002);
    mode = vga_status_pkg::mode_centered;
    repeat (2) @(negedge mclk);
    chk("dot fixed", {13'h0, dsel, dfix}, 16'h0001);
    mode = vga_status_pkg::mode_native;
    repeat (2) @(negedge mclk);
    chk("dot native", {13'h0, dsel, dfix}, 16'h0002);
    mode = vga_status_pkg::mode_upper_left;
    repeat (2) @(negedge mclk);
    chk("dot corner", {13'h0, dsel, dfix}, 16'h0001);
    mode = vga_status_pkg::mode_native;
    stat(8'h40, 16'h0009);
    stat(8'h20, 16'h0001);
    stat(8'h0F, 16'h0000);
    stat(8'hFC, 16'h0000);
    stat(8'h92, 16'h0009);
    stat(8'h84, 16'h0001);
    sv = 8'h00;
    pal = 8'hB4;
    for (int i = 0; i < 4; i++)
    begin
      psl = 2'(i);
      stat(8'h00, ((16'(pal) >> (2 * i)) & 16'h0003) << 4);
    end
    // mid-run reset must bring the misc register back to mono decode
    @(negedge mclk);
    nrst = 1'b0;
    repeat (2) @(negedge mclk);
    nrst = 1'b1;
    rd(16'h03CC, 2'b01, 16'h0000, 1'b1);
    rd(16'h03BA, 2'b01, 16'h0020, 1'b1);
    complete_run();
  end
endmodule
`default_nettype wire
